/* File: core/btpc_core.sv */
// Program counter with branch target selection and vector table fetch
`timescale 1ns/1ps
// How it works
// - No branch: add fetched instruction length.
// - Taken branch loads target, not increment.
// - Relative target is following address plus displacement.
// - Displacement signed, bit 7 sign.
// - Sign-extend displacement before adding.
// - Short jump and conditional branches use relative.
// - Immediate field goes straight into counter.
// - Short area call lands in 0800H-0FFFH.
// - Opcode bits 1-5 select vector entry.
// - Vector call loads address read from entry.
// - Register jump loads accumulator pair.
module btpc_core #(
    parameter int ADDR_W = 16
) (
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic              step,
    input  wire logic [2:0]        mode,
    input  wire logic [2:0]        length,
    input  wire logic [15:0]       imm_field,
    input  wire logic [15:0]       accumulator_pair,
    input  wire logic [7:0]        table_data,
    input  wire logic              table_valid,
    output logic      [ADDR_W-1:0] pc,
    output logic      [ADDR_W-1:0] table_addr,
    output logic                   table_req,
    output logic                   busy,
    output logic      [ADDR_W-1:0] return_pc
);
    btpc_pkg::btpc_state_t state;
    btpc_pkg::btpc_state_t next_state;
    logic [ADDR_W-1:0]     next_pc;
    logic [ADDR_W-1:0]     following_pc;
    logic [ADDR_W-1:0]     vector_addr;
    logic [7:0]            low_byte;
    logic                  accept;
    logic                  vec_start;

    btpc_target #(
        .ADDR_W (ADDR_W)
    ) u_target (
        .mode             (mode),
        .pc               (pc),
        .length           (length),
        .imm_field        (imm_field),
        .accumulator_pair (accumulator_pair),
        .next_pc          (next_pc),
        .following_pc     (following_pc),
        .vector_addr      (vector_addr)
    );

    // Steps are ignored while a vector fetch is in flight
    assign accept    = step && (state == btpc_pkg::BTPC_IDLE);
    assign vec_start = accept && (mode == 3'(btpc_pkg::BTPC_VECTOR_TABLE));

    // Vector fetch sequencer: low byte, then high byte
    always_comb begin
        next_state = state;
        case (state)
            btpc_pkg::BTPC_IDLE:     if (vec_start) next_state = btpc_pkg::BTPC_VEC_LOW;
            btpc_pkg::BTPC_VEC_LOW:  if (table_valid) next_state = btpc_pkg::BTPC_VEC_HIGH;
            btpc_pkg::BTPC_VEC_HIGH: if (table_valid) next_state = btpc_pkg::BTPC_IDLE;
            default:                 next_state = btpc_pkg::BTPC_IDLE;
        endcase
    end

    // State register; the sequencer only leaves idle on a vector call
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= btpc_pkg::BTPC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Program counter load; the vector path waits for both bytes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pc <= btpc_pkg::PC_RESET;
        end else if (accept && !vec_start) begin
            pc <= next_pc;
        end else if (state == btpc_pkg::BTPC_VEC_HIGH && table_valid) begin
            pc <= {table_data, low_byte};
        end
    end

    // Return address kept for calls; the stack is outside this block
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            return_pc <= btpc_pkg::PC_RESET;
        end else if (accept) begin
            return_pc <= following_pc;
        end
    end

    // Table read port; request held until the high byte arrives
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            table_addr <= btpc_pkg::PC_RESET;
            table_req  <= 1'h0;
            busy       <= 1'h0;
            low_byte   <= 8'h00;
        end else begin
            if (vec_start) begin
                table_addr <= vector_addr;
                table_req  <= 1'h1;
                busy       <= 1'h1;
            end else if (state == btpc_pkg::BTPC_VEC_LOW && table_valid) begin
                low_byte   <= table_data;
                table_addr <= ADDR_W'(table_addr + 16'h0001);
            end else if (state == btpc_pkg::BTPC_VEC_HIGH && table_valid) begin
                table_req  <= 1'h0;
                busy       <= 1'h0;
            end
        end
    end

    // Checks on the counter
    sequence seq_vec_done;
        state == btpc_pkg::BTPC_VEC_HIGH && table_valid;
    endsequence

    seq_incr_a: assert property (@(posedge clock) disable iff (!resetn)
        accept && mode == 3'(btpc_pkg::BTPC_SEQUENTIAL)
        |=> pc == ADDR_W'($past(pc) + ADDR_W'($past(length))))
        else $error("pc did not advance by length");
    rel_target_a: assert property (@(posedge clock) disable iff (!resetn)
        accept && mode == 3'(btpc_pkg::BTPC_RELATIVE)
        |=> pc == ADDR_W'($past(pc) + ADDR_W'($past(length))
                 + {{8{$past(imm_field[7])}}, $past(imm_field[7:0])}))
        else $error("relative target wrong");
    imm_load_a: assert property (@(posedge clock) disable iff (!resetn)
        accept && mode == 3'(btpc_pkg::BTPC_IMMEDIATE16) |=> pc == $past(imm_field))
        else $error("immediate target wrong");
    short_area_a: assert property (@(posedge clock) disable iff (!resetn)
        accept && mode == 3'(btpc_pkg::BTPC_SHORT_AREA)
        |=> pc >= btpc_pkg::SHORT_AREA_LO && pc <= btpc_pkg::SHORT_AREA_HI)
        else $error("short call left its area");
    reg_jump_a: assert property (@(posedge clock) disable iff (!resetn)
        accept && mode == 3'(btpc_pkg::BTPC_REGISTER) |=> pc == $past(accumulator_pair))
        else $error("register jump target wrong");
    vec_range_a: assert property (@(posedge clock) disable iff (!resetn)
        table_req |-> table_addr >= btpc_pkg::VECTOR_BASE && table_addr <= btpc_pkg::VECTOR_TOP)
        else $error("vector address outside table");
    vec_even_a: assert property (@(posedge clock) disable iff (!resetn)
        vec_start |=> table_addr[0] == 1'h0)
        else $error("vector entry not even");
    vec_load_a: assert property (@(posedge clock) disable iff (!resetn)
        seq_vec_done |=> pc == {$past(table_data), $past(low_byte)} && !busy)
        else $error("vector target wrong");
    vec_hold_a: assert property (@(posedge clock) disable iff (!resetn)
        busy && !(state == btpc_pkg::BTPC_VEC_HIGH && table_valid) |=> pc == $past(pc))
        else $error("pc moved during vector fetch");

    // Further checks; each step kind is named once as a sequence and reused below
    sequence seq_plain_step;
        accept && !vec_start;
    endsequence

    // Relative step with the sign bit clear: the target lies ahead
    sequence seq_rel_fwd;
        accept && mode == 3'(btpc_pkg::BTPC_RELATIVE) && !imm_field[btpc_pkg::SIGN_BIT];
    endsequence

    // Relative step with the sign bit set: the target lies behind
    sequence seq_rel_back;
        accept && mode == 3'(btpc_pkg::BTPC_RELATIVE) && imm_field[btpc_pkg::SIGN_BIT];
    endsequence

    // Short area call taken
    sequence seq_short_call;
        accept && mode == 3'(btpc_pkg::BTPC_SHORT_AREA);
    endsequence

    // Vector fetch launched, then its low byte taken
    sequence seq_vec_start;
        vec_start;
    endsequence

    sequence seq_vec_low;
        state == btpc_pkg::BTPC_VEC_LOW && table_valid;
    endsequence

    // Differences are taken modulo the counter width, so wrapped targets still pass
    rel_fwd_a: assert property (@(posedge clock) disable iff (!resetn)
        seq_rel_fwd |=> ADDR_W'(pc - $past(following_pc)) <= 16'h007f)
        else $error("forward displacement out of reach");
    rel_back_a: assert property (@(posedge clock) disable iff (!resetn)
        seq_rel_back |=> ADDR_W'(pc - $past(following_pc)) >= 16'hff80)
        else $error("negative displacement not sign extended");
    short_field_a: assert property (@(posedge clock) disable iff (!resetn)
        seq_short_call |=> pc[10:0] == $past(imm_field[10:0]))
        else $error("short call field not carried over");
    step_load_a: assert property (@(posedge clock) disable iff (!resetn)
        seq_plain_step |=> pc == $past(next_pc) && !busy)
        else $error("taken step did not load the formed target");
    ret_addr_a: assert property (@(posedge clock) disable iff (!resetn)
        accept |=> return_pc == ADDR_W'($past(pc) + ADDR_W'($past(length))))
        else $error("return address is not the following instruction");

    // A fetch that opens badly would leave the core waiting for ever
    vec_begin_a: assert property (@(posedge clock) disable iff (!resetn)
        seq_vec_start |=> table_req && busy && pc == $past(pc))
        else $error("vector fetch did not start");
    vec_next_a: assert property (@(posedge clock) disable iff (!resetn)
        seq_vec_low |=> table_addr == ADDR_W'($past(table_addr) + 16'h0001) && table_addr[0])
        else $error("high byte not read from the next address");
    vec_step_a: assert property (@(posedge clock) disable iff (!resetn)
        seq_vec_start ##1 seq_vec_low |=> state == btpc_pkg::BTPC_VEC_HIGH && busy)
        else $error("sequencer skipped the high byte");
    req_busy_a: assert property (@(posedge clock) disable iff (!resetn)
        table_req == busy)
        else $error("request and busy disagree");
    idle_quiet_a: assert property (@(posedge clock) disable iff (!resetn)
        !busy |-> state == btpc_pkg::BTPC_IDLE)
        else $error("sequencer active while not busy");
    busy_hold_a: assert property (@(posedge clock) disable iff (!resetn)
        busy |=> return_pc == $past(return_pc))
        else $error("step taken while a vector fetch was running");
endmodule

/* File: core/btpc_pkg.sv */
// Package for the branch target program counter logic: widths, vectors, modes
package btpc_pkg;
    localparam int          ADDR_W         = 16;
    localparam logic [15:0] PC_RESET       = 16'h0000;
    localparam logic [15:0] SHORT_AREA_LO  = 16'h0800;
    localparam logic [15:0] SHORT_AREA_HI  = 16'h0fff;
    localparam logic [15:0] VECTOR_BASE    = 16'h0040;
    localparam logic [15:0] VECTOR_TOP     = 16'h007f;
    localparam int          VEC_SEL_LSB    = 1;
    localparam int          VEC_SEL_MSB    = 5;
    localparam int          SIGN_BIT       = 7;
    localparam int          SHORT_FIELD_W  = 11;

    // Target formation method requested by the decoder
    typedef enum logic [2:0] {
        BTPC_SEQUENTIAL   = 3'h0,
        BTPC_RELATIVE     = 3'h1,
        BTPC_IMMEDIATE16  = 3'h3,
        BTPC_SHORT_AREA   = 3'h2,
        BTPC_VECTOR_TABLE = 3'h6,
        BTPC_REGISTER     = 3'h7
    } btpc_mode_t;

    // Vector fetch sequencer
    typedef enum logic [1:0] {
        BTPC_IDLE    = 2'h0,
        BTPC_VEC_LOW = 2'h1,
        BTPC_VEC_HIGH = 2'h3
    } btpc_state_t;
endpackage

/* File: core/btpc_target.sv */
// Combinational target address former for all branch addressing methods
`timescale 1ns/1ps
module btpc_target #(
    parameter int ADDR_W = 16
) (
    input  wire logic [2:0]        mode,
    input  wire logic [ADDR_W-1:0] pc,
    input  wire logic [2:0]        length,
    input  wire logic [15:0]       imm_field,
    input  wire logic [15:0]       accumulator_pair,
    output logic      [ADDR_W-1:0] next_pc,
    output logic      [ADDR_W-1:0] following_pc,
    output logic      [ADDR_W-1:0] vector_addr
);
    logic [ADDR_W-1:0] disp_ext;

    // Carry out of the top bit is dropped by the width of the sum
    assign following_pc = ADDR_W'(pc + ADDR_W'(length));

    // Replicate bit 7 over all upper bits
    assign disp_ext = {{(ADDR_W-8){imm_field[btpc_pkg::SIGN_BIT]}},
                       imm_field[7:0]};

    // Entry index times two keeps every entry on an even address
    assign vector_addr = btpc_pkg::VECTOR_BASE
                       | {10'h000,
                          imm_field[btpc_pkg::VEC_SEL_MSB:btpc_pkg::VEC_SEL_LSB],
                          1'h0};

    // Select the method; the vector case is finished by the sequencer
    always_comb begin
        case (btpc_pkg::btpc_mode_t'(mode))
            btpc_pkg::BTPC_SEQUENTIAL:  next_pc = following_pc;
            btpc_pkg::BTPC_RELATIVE: begin
                next_pc = ADDR_W'(following_pc + disp_ext);
            end
            btpc_pkg::BTPC_IMMEDIATE16: next_pc = imm_field;
            btpc_pkg::BTPC_SHORT_AREA: begin
                next_pc = btpc_pkg::SHORT_AREA_LO | {5'h00, imm_field[10:0]};
            end
            btpc_pkg::BTPC_REGISTER:    next_pc = accumulator_pair;
            default:                    next_pc = following_pc;
        endcase
    end
endmodule

/* File: testbench/btpc_table_model.sv */
// Vector table memory model answering byte reads after a programmable wait
`timescale 1ns/1ps
module btpc_table_model (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        table_req,
    input  wire logic [15:0] table_addr,
    input  wire logic [3:0]  delay,
    output logic      [7:0]  table_data,
    output logic             table_valid
);
    logic [3:0] wait_cnt;
    logic [7:0] last_data;

    // Byte is offered once the wait has run out; each address waits afresh
    assign table_valid = table_req && (wait_cnt == delay);
    // Entries are byte wide, so a 16-bit target spans two bytes
    // Outside a valid cycle the data is scrambled so no stale byte passes
    assign table_data  = table_valid ? (table_addr[7:0] ^ 8'h5a) : ~last_data;

    // Wait counter restarts after every delivered byte
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wait_cnt <= 4'h0;
        end else if (!table_req || table_valid) begin
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end

    // Remember the last byte to scramble the idle bus
    always_ff @(posedge clock) begin
        if (table_valid) begin
            last_data <= table_data;
        end
    end
endmodule

/* File: testbench/branch_target_pc_logic_test.sv */
// Self-checking bench for the program counter and branch target logic
`timescale 1ns/1ps
`define CHECK(got, want) begin compares++; if ((got) !== (want)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h want %h", $time, got, want); end end
module branch_target_pc_logic_test;
    logic        clock, resetn, step, table_valid, table_req, busy;
    logic [2:0]  mode, length;
    logic [15:0] imm_field, accumulator_pair, pc, table_addr, return_pc, exp_pc;
    logic [7:0]  table_data;
    logic [3:0]  delay;
    int          n_mismatch, compares;

    btpc_core btpc_core_inst (.clock(clock), .resetn(resetn), .step(step), .mode(mode),
        .length(length), .imm_field(imm_field), .accumulator_pair(accumulator_pair),
        .table_data(table_data), .table_valid(table_valid), .pc(pc),
        .table_addr(table_addr), .table_req(table_req), .busy(busy), .return_pc(return_pc));
    btpc_table_model btpc_table_model_inst (.clock(clock), .resetn(resetn),
        .table_req(table_req), .table_addr(table_addr), .delay(delay),
        .table_data(table_data), .table_valid(table_valid));

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One accepted step; step stays high so back-to-back steps need no gap
    task automatic run(input logic [2:0] m, input logic [2:0] len, input logic [15:0] imm,
                       input logic [15:0] want);
        step = 1'h1;
        mode = m;
        length = len;
        imm_field = imm;
        @(posedge clock);
        #1;
        `CHECK(pc, want)
        `CHECK(return_pc, 16'(exp_pc + len))
        exp_pc = want;
    endtask

    function automatic logic [7:0] entry(input logic [15:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction

    // Vector call; a held register jump must be ignored while busy
    task automatic t_vec(input logic [15:0] imm, input logic [3:0] d);
        logic [15:0] a;
        int          n;
        a = 16'h0040 | {10'h000, imm[5:1], 1'h0};
        delay = d;
        accumulator_pair = 16'hdead;
        step = 1'h1;
        mode = 3'h6;
        imm_field = imm;
        @(posedge clock);
        #1;
        mode = 3'h7;
        `CHECK(busy, 1'h1)
        `CHECK(table_addr, a)
        `CHECK(pc, exp_pc)
        `CHECK(return_pc, 16'(exp_pc + length))
        n = 1;
        while (busy !== 1'h0 && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        step = 1'h0;
        if (n >= 40) begin
            n_mismatch++;
            print_verdict();
        end else begin
            // Start edge, one edge per byte, plus the wait in front of each byte
            `CHECK(n, 3 + 2 * d)
            `CHECK(table_addr, a | 16'h0001)
            `CHECK(table_req, 1'h0)
            exp_pc = {entry(a | 16'h0001), entry(a)};
            `CHECK(pc, exp_pc)
            @(posedge clock);
            #1;
            `CHECK(pc, exp_pc)
        end
    endtask

    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end

    // Walk each addressing method, chaining expected counter values
    initial begin
        resetn = 1'h0;
        step = 1'h0;
        mode = 3'h0;
        length = 3'h0;
        imm_field = 16'h0000;
        accumulator_pair = 16'h0000;
        delay = 4'h0;
        n_mismatch = 0;
        compares = 0;
        exp_pc = 16'h0000;
        repeat (5) @(posedge clock);
        #1;
        `CHECK(busy, 1'h0)
        resetn = 1'h1;
        run(3'h0, 3'h1, 16'h0000, 16'h0001);
        run(3'h0, 3'h4, 16'h1234, 16'h0005);
        run(3'h5, 3'h2, 16'hffff, 16'h0007);
        run(3'h1, 3'h2, 16'hab7f, 16'h0088);
        run(3'h1, 3'h2, 16'h0080, 16'h000a);
        run(3'h3, 3'h3, 16'hfff0, 16'hfff0);
        run(3'h1, 3'h2, 16'h0020, 16'h0012);
        run(3'h1, 3'h1, 16'h00ff, 16'h0012);
        run(3'h2, 3'h3, 16'hf7ff, 16'h0fff);
        run(3'h2, 3'h3, 16'hf800, 16'h0800);
        accumulator_pair = 16'hc35a;
        run(3'h7, 3'h1, 16'h1111, 16'hc35a);
        t_vec(16'h003e, 4'h0);
        t_vec(16'h0001, 4'h3);
        resetn = 1'h0;
        #1;
        `CHECK(pc, 16'h0000)
        `CHECK(table_req, 1'h0)
        print_verdict();
    end
endmodule
